//--- common/isc_pkg.sv
/*
  Shared constants and types of the interrupt status and command register group.
  Assumes a 32-bit APB with byte addresses and one aligned word per register.
*/
package isc_pkg;

    localparam int          ISC_AW          = 12;
    localparam int          ISC_DW          = 32;
    localparam int          ISC_NSRC        = 32;
    localparam int          ISC_IDW         = 5;

    localparam logic [11:0] ISC_OFS_SVR0    = 12'h080;
    localparam logic [11:0] ISC_OFS_SVR31   = 12'h0FC;
    localparam logic [11:0] ISC_OFS_IVR     = 12'h100;
    localparam logic [11:0] ISC_OFS_FVR     = 12'h104;
    localparam logic [11:0] ISC_OFS_CUR     = 12'h108;
    localparam logic [11:0] ISC_OFS_PEND    = 12'h10C;
    localparam logic [11:0] ISC_OFS_MASK    = 12'h110;
    localparam logic [11:0] ISC_OFS_CORE    = 12'h114;
    localparam logic [11:0] ISC_OFS_EN      = 12'h120;
    localparam logic [11:0] ISC_OFS_DIS     = 12'h124;
    localparam logic [11:0] ISC_OFS_CLR     = 12'h128;
    localparam logic [11:0] ISC_OFS_SET     = 12'h12C;
    localparam logic [11:0] ISC_OFS_EOS     = 12'h130;
    localparam logic [11:0] ISC_OFS_SPU     = 12'h134;
    localparam logic [11:0] ISC_OFS_EVSTAT  = 12'h150;
    localparam logic [11:0] ISC_OFS_EVEN    = 12'h154;
    localparam logic [11:0] ISC_OFS_EVCLR   = 12'h158;

    localparam int          ISC_FAST_BIT    = 0;
    localparam int          ISC_SYS_BIT     = 1;
    localparam int          ISC_CORE_FAST   = 0;
    localparam int          ISC_CORE_NORM   = 1;
    localparam int          ISC_EV_TAKE     = 0;
    localparam int          ISC_EV_DONE     = 1;
    localparam int          ISC_NEV         = 2;

    localparam logic [31:0] ISC_RST_WORD    = 32'h0000_0000;
    localparam logic [4:0]  ISC_RST_ID      = 5'h00;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } isc_apb_req_t;

    typedef struct packed {
        logic        fast_req_n;
        logic        norm_req_n;
    } isc_core_req_t;

endpackage

//--- core/isc_regs.sv
/*
  Status and command register group of a vectored interrupt controller:
  pending and mask bits, current source, request lines to the core, vectors.
  Assumes an APB master on pclk and source levels from logic on the same clock.
*/
`timescale 1ns/1ns

// Summary of operation
// [RL1] Status register returns current serviced source number.
// [RL2] Pending bits show pending sources; reset zero.
// [RL3] Bit 0 fast, bit 1 system, rest peripherals.
// [RL4] Mask bits show enabled sources; reset disabled.
// [RL5] Core status bit 0 mirrors fast request.
// [RL6] Core status bit 1 mirrors normal request.
// [RL7] Enable command ones set mask bits.
// [RL8] Disable command ones clear mask bits.
// [RL9] Clear command ones clear pending bits.
// [RL10] Set command ones make sources pending.
// [RL11] Any end-of-service write ends current treatment.
// [RL12] Handler writes end-of-service when servicing is done.
// [RL13] Spurious vector returned when no interrupt present.
// [RL14] Current source number indexes the vector read.
// [RL15] Command reads return zero; effects visible next read.
module isc_regs
    import isc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [ISC_NSRC-1:0] src_level,
    output logic                     fast_request_output_n,
    output logic                     normal_request_output_n,
    output logic      [ISC_IDW-1:0]  current_source_number,
    output logic                     bus_irq
);

    isc_apb_req_t              req;
    isc_core_req_t             core_r;
    logic                      pready_r;
    logic                      pslverr_r;
    logic [31:0]               prdata_r;
    logic [31:0]               prdata_nxt;
    logic                      hit_nxt;
    logic                      acc;
    logic                      wr;
    logic [ISC_NSRC-1:0]       pend_r;
    logic [ISC_NSRC-1:0]       mask_r;
    logic [ISC_NSRC-1:0]       src_d_r;
    logic [ISC_NSRC-1:0]       cmd_en;
    logic [ISC_NSRC-1:0]       cmd_dis;
    logic [ISC_NSRC-1:0]       cmd_clr;
    logic [ISC_NSRC-1:0]       cmd_set;
    logic [ISC_NSRC-1:0]       done_clr;
    logic [ISC_NSRC-1:0]       active;
    logic                      eos_wr;
    logic                      busy_r;
    logic [ISC_IDW-1:0]        cur_r;
    logic [ISC_IDW-1:0]        pick;
    logic                      pick_ok;
    logic                      take;
    logic [31:0]               spu_r;
    logic [31:0]               vec_r [ISC_NSRC];
    logic [ISC_NEV-1:0]        ev_stat_r;
    logic [ISC_NEV-1:0]        ev_en_r;
    logic [ISC_NEV-1:0]        ev_set;
    logic [ISC_NEV-1:0]        ev_clr;
    logic                      bus_irq_r;
    logic [ISC_IDW-1:0]        svr_idx;
    logic                      svr_hit;

    assign req.addr  = paddr[11:0];
    assign req.write = pwrite;
    assign req.wdata = pwdata;

    // The access is taken only at the edge where pready is seen high.
    assign acc = psel && penable && pready_r;
    assign wr  = acc && req.write;

    assign svr_hit = (req.addr >= ISC_OFS_SVR0) && (req.addr <= ISC_OFS_SVR31)
                     && (req.addr[1:0] == 2'b00);
    assign svr_idx = req.addr[6:2];

    // Command strobes, one cycle wide, aligned with the completing edge.
    assign cmd_en  = (wr && req.addr == ISC_OFS_EN)  ? req.wdata : '0;
    assign cmd_dis = (wr && req.addr == ISC_OFS_DIS) ? req.wdata : '0;
    assign cmd_clr = (wr && req.addr == ISC_OFS_CLR) ? req.wdata : '0;
    assign cmd_set = (wr && req.addr == ISC_OFS_SET) ? req.wdata : '0;
    // The data word is ignored; only the write itself counts.  // see [RL11]
    assign eos_wr  = wr && (req.addr == ISC_OFS_EOS);

    assign ev_clr  = (wr && req.addr == ISC_OFS_EVCLR) ? req.wdata[ISC_NEV-1:0]
                                                       : '0;

    assign active = pend_r & mask_r;

    // Lowest numbered normal source wins; arbitration by priority lives
    // outside this group, so a fixed order stands in for it here.
    always_comb begin
        pick    = ISC_RST_ID;
        pick_ok = 1'b0;
        for (int i = ISC_NSRC - 1; i > ISC_FAST_BIT; i--) begin
            if (active[i]) begin
                pick    = ISC_IDW'(i);
                pick_ok = 1'b1;
            end
        end
    end

    assign take = !busy_r && pick_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_d_r <= ISC_RST_WORD;
        end else begin
            src_d_r <= src_level;
        end
    end

    // Treatment of the current source ends on the end-of-service write, which
    // also drops that source's pending bit so it is not taken twice.
    always_comb begin
        done_clr = '0;
        if (eos_wr && busy_r) begin // see [RL11] [RL12]
            done_clr[cur_r] = 1'b1;
        end
    end

    // One pending and one mask flip-flop per source; all per-source registers
    // share one map: fast at bit 0, system at bit 1, peripherals above.
    for (genvar g = 0; g < ISC_NSRC; g++) begin : g_src // see [RL3]
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pend_r[g] <= 1'b0; // see [RL2]
            end else if (cmd_set[g] || (src_level[g] && !src_d_r[g])) begin
                // A new event wins over a clear in the same cycle.
                pend_r[g] <= 1'b1; // see [RL10]
            end else if (cmd_clr[g] || done_clr[g]) begin
                pend_r[g] <= 1'b0; // see [RL9]
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mask_r[g] <= 1'b0; // see [RL4]
            end else if (cmd_en[g]) begin
                mask_r[g] <= 1'b1; // see [RL7]
            end else if (cmd_dis[g]) begin
                mask_r[g] <= 1'b0; // see [RL8]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            cur_r  <= ISC_RST_ID;
        end else if (take) begin
            busy_r <= 1'b1;
            cur_r  <= pick; // see [RL1]
        end else if (eos_wr) begin
            busy_r <= 1'b0; // see [RL11]
        end
    end

    // Request lines are active low and fed only from registered state, so
    // the core status bits read exactly what the pins show.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_r.fast_req_n <= 1'b1;
            core_r.norm_req_n <= 1'b1;
        end else begin
            core_r.fast_req_n <= !active[ISC_FAST_BIT];
            core_r.norm_req_n <= !busy_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spu_r <= ISC_RST_WORD;
        end else if (wr && req.addr == ISC_OFS_SPU) begin
            spu_r <= req.wdata; // see [RL13]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ISC_NSRC; i++) begin
                vec_r[i] <= ISC_RST_WORD;
            end
        end else if (wr && svr_hit) begin
            vec_r[svr_idx] <= req.wdata;
        end
    end

    assign ev_set[ISC_EV_TAKE] = take;
    assign ev_set[ISC_EV_DONE] = eos_wr && busy_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat_r <= '0;
        end else begin
            ev_stat_r <= ev_set | (ev_stat_r & ~ev_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_en_r <= '0;
        end else if (wr && req.addr == ISC_OFS_EVEN) begin
            ev_en_r <= req.wdata[ISC_NEV-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_irq_r <= 1'b0;
        end else begin
            bus_irq_r <= |(ev_stat_r & ev_en_r);
        end
    end

    // Read mux; write-only commands answer zero and reads never have effects.
    always_comb begin
        prdata_nxt = ISC_RST_WORD;
        hit_nxt    = 1'b1;
        if (svr_hit) begin
            prdata_nxt = vec_r[svr_idx];
        end else begin
            unique case (req.addr)
                ISC_OFS_IVR: begin
                    prdata_nxt = busy_r ? vec_r[cur_r] : spu_r; // see [RL14] [RL13]
                end
                ISC_OFS_FVR: begin
                    prdata_nxt = active[ISC_FAST_BIT] ? vec_r[ISC_FAST_BIT]
                                                      : spu_r; // see [RL13]
                end
                ISC_OFS_CUR: begin
                    prdata_nxt = {27'h000_0000, cur_r}; // see [RL1]
                end
                ISC_OFS_PEND: begin
                    prdata_nxt = pend_r; // see [RL2]
                end
                ISC_OFS_MASK: begin
                    prdata_nxt = mask_r; // see [RL4]
                end
                ISC_OFS_CORE: begin
                    prdata_nxt[ISC_CORE_FAST] = !core_r.fast_req_n; // see [RL5]
                    prdata_nxt[ISC_CORE_NORM] = !core_r.norm_req_n; // see [RL6]
                end
                ISC_OFS_EN, ISC_OFS_DIS, ISC_OFS_CLR, ISC_OFS_SET,
                ISC_OFS_EOS, ISC_OFS_EVCLR: begin
                    prdata_nxt = ISC_RST_WORD; // see [RL15]
                end
                ISC_OFS_SPU: begin
                    prdata_nxt = spu_r;
                end
                ISC_OFS_EVSTAT: begin
                    prdata_nxt[ISC_NEV-1:0] = ev_stat_r;
                end
                ISC_OFS_EVEN: begin
                    prdata_nxt[ISC_NEV-1:0] = ev_en_r;
                end
                default: begin
                    hit_nxt = 1'b0;
                end
            endcase
        end
    end

    // One wait state: pready rises in the second access cycle, and the read
    // word is sampled then, so changes from an earlier command are visible.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= ISC_RST_WORD;
        end else if (psel && penable && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= !hit_nxt || (paddr[31:12] != 20'h0_0000); // see [RL15]
            prdata_r  <= req.write ? ISC_RST_WORD : prdata_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= ISC_RST_WORD;
        end
    end

    assign prdata                  = prdata_r;
    assign pready                  = pready_r;
    assign pslverr                 = pslverr_r;
    assign fast_request_output_n   = core_r.fast_req_n;
    assign normal_request_output_n = core_r.norm_req_n;
    assign current_source_number   = cur_r;
    assign bus_irq                 = bus_irq_r;

endmodule // isc_regs

//--- testbench/isc_core_model.sv
/* Behavioural processor core that watches the two request lines.
   Assumes active-low request lines registered on pclk. */
`timescale 1ns/1ns
module isc_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       fast_request_output_n,
    input  wire logic       normal_request_output_n,
    output logic      [7:0] norm_entries,
    output logic      [7:0] fast_entries
);
    logic norm_r;
    logic fast_r;
    // A handler starts on each new assertion, so a line held low is one entry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            norm_r <= 1'b1;
            fast_r <= 1'b1;
            norm_entries <= 8'h00;
            fast_entries <= 8'h00;
        end else begin
            norm_r <= normal_request_output_n;
            fast_r <= fast_request_output_n;
            if (norm_r && !normal_request_output_n) norm_entries <= norm_entries + 8'h01;
            if (fast_r && !fast_request_output_n) fast_entries <= fast_entries + 8'h01;
        end
    end
endmodule // isc_core_model

//--- testbench/isc_regs_chk.sv
/* Port checker for isc_regs.
   Assumes an APB master that holds each request until pready. */
`timescale 1ns/1ns
module isc_regs_chk
    import isc_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               fast_request_output_n,
    input wire logic               normal_request_output_n,
    input wire logic [ISC_IDW-1:0] current_source_number
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_x;
    logic cmd_x;
    logic eos_x;
    assign rd_x = psel && penable && pready && !pwrite;
    assign cmd_x = paddr[11:0] inside {ISC_OFS_EN, ISC_OFS_DIS, ISC_OFS_CLR, ISC_OFS_SET};
    assign eos_x = psel && penable && pready && pwrite && paddr[11:0] == ISC_OFS_EOS;
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    idle_data_a: assert property (!pready |-> prdata == ISC_RST_WORD)
        else $error("read data outside answer");
    cmd_zero_a: assert property (rd_x && cmd_x |-> prdata == 0 && !pslverr)
        else $error("command register read not zero");
    core_status_a: assert property (rd_x && paddr[11:0] == ISC_OFS_CORE |->
        prdata == {30'h0, !$past(normal_request_output_n),
        !$past(fast_request_output_n)})
        else $error("core status differs from lines");
    cur_read_a: assert property (rd_x && paddr[11:0] == ISC_OFS_CUR |->
        prdata == {27'h000_0000, $past(current_source_number)})
        else $error("current source read wrong");
    cur_hold_a: assert property (!normal_request_output_n |-> $stable(current_source_number))
        else $error("source changed in service");
    eos_release_a: assert property (eos_x && !normal_request_output_n |->
        ##[1:3] normal_request_output_n)
        else $error("request not released after end of service");
endmodule // isc_regs_chk

bind isc_regs isc_regs_chk u_chk (
    .pclk,
    .presetn,
    .psel,
    .penable,
    .pwrite,
    .paddr,
    .prdata,
    .pready,
    .pslverr,
    .fast_request_output_n,
    .normal_request_output_n,
    .current_source_number
);

//--- testbench/isc_regs_tb_top.sv
/* Testbench top for isc_regs: register table, a service cycle, events, reset.
   Assumes a 25 MHz pclk and the core model beside the design. */
`timescale 1ns/1ns
module isc_regs_tb_top
    import isc_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic        w;
        logic [31:0] d;
    } isc_row_t;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] src_level;
    logic fast_n;
    logic norm_n;
    logic [4:0] cur;
    logic bus_irq;
    logic [7:0] n_ent;
    logic [7:0] f_ent;
    logic [31:0] rdat;
    logic rerr;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    // Writes carry data in d; reads carry the expected word in d.
    isc_row_t rows [16] = '{
        '{ISC_OFS_PEND, 1'b0, 32'h0000_0000}, '{ISC_OFS_MASK, 1'b0, 32'h0000_0000},
        '{ISC_OFS_CORE, 1'b0, 32'h0000_0000}, '{ISC_OFS_SPU, 1'b1, 32'hA5A5_5A5A},
        '{ISC_OFS_SPU, 1'b0, 32'hA5A5_5A5A}, '{ISC_OFS_EN, 1'b1, 32'h8000_0005},
        '{ISC_OFS_MASK, 1'b0, 32'h8000_0005}, '{ISC_OFS_DIS, 1'b1, 32'h8000_0004},
        '{ISC_OFS_MASK, 1'b0, 32'h0000_0001}, '{ISC_OFS_EN, 1'b0, 32'h0000_0000},
        '{ISC_OFS_SET, 1'b1, 32'h0000_0011}, '{ISC_OFS_PEND, 1'b0, 32'h0000_0011},
        '{ISC_OFS_CORE, 1'b0, 32'h0000_0001}, '{ISC_OFS_CLR, 1'b1, 32'h0000_0011},
        '{ISC_OFS_PEND, 1'b0, 32'h0000_0000}, '{ISC_OFS_CORE, 1'b0, 32'h0000_0000}};

    isc_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .src_level,
        .fast_request_output_n(fast_n), .normal_request_output_n(norm_n),
        .current_source_number(cur), .bus_irq);
    isc_core_model u_core (.pclk, .presetn, .fast_request_output_n(fast_n),
        .normal_request_output_n(norm_n), .norm_entries(n_ent), .fast_entries(f_ent));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    // The answer is taken at the rising edge where pready is sampled high; the
    // values read just after the edge are those the design saw at it.
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {20'h0_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rdat, e);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        src_level = 32'h0000_0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk(rdat, rows[i].d);
        end
        chk({24'h00_0000, f_ent}, 32'h0000_0001);
        xfer(12'h13C, 1'b0, 32'h0000_0000);
        chk({31'h0, rerr}, 32'h0000_0001);
        xfer(ISC_OFS_SVR0 + 12'h014, 1'b1, 32'h0000_1234);
        xfer(ISC_OFS_EVEN, 1'b1, 32'h0000_0001);
        xfer(ISC_OFS_EN, 1'b1, 32'h0000_0020);
        src_level[5] <= 1'b1;
        while (n_ent == 8'h00) @(negedge pclk);
        rd(ISC_OFS_CUR, 32'h0000_0005);
        rd(ISC_OFS_IVR, 32'h0000_1234);
        rd(ISC_OFS_CORE, 32'h0000_0002);
        chk({31'h0, bus_irq}, 32'h0000_0001);
        xfer(ISC_OFS_EVEN, 1'b1, 32'h0000_0000);
        rd(ISC_OFS_EVSTAT, 32'h0000_0001);
        chk({31'h0, bus_irq}, 32'h0000_0000);
        src_level[5] <= 1'b0;
        xfer(ISC_OFS_EOS, 1'b1, 32'hDEAD_BEEF);
        rd(ISC_OFS_CORE, 32'h0000_0000);
        rd(ISC_OFS_IVR, 32'hA5A5_5A5A);
        rd(ISC_OFS_FVR, 32'hA5A5_5A5A);
        rd(ISC_OFS_PEND, 32'h0000_0000);
        rd(ISC_OFS_EVSTAT, 32'h0000_0003);
        xfer(ISC_OFS_EVCLR, 1'b1, 32'h0000_0003);
        xfer(ISC_OFS_EVEN, 1'b1, 32'h0000_0003);
        rd(ISC_OFS_EVSTAT, 32'h0000_0000);
        chk({31'h0, bus_irq}, 32'h0000_0000);
        chk({24'h00_0000, n_ent}, 32'h0000_0001);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ISC_OFS_MASK, 32'h0000_0000);
        rd(ISC_OFS_SPU, 32'h0000_0000);
        complete_run();
    end
endmodule // isc_regs_tb_top
